// >>> hw/ssr_status_top.sv
// System status readback register with reset-cause capture and sleep entry
//
// Summary of operation
// - Frame bits 15,14 at 00 and bit 13 at 0 select the status register.
// - Bit 12 high reads only; bit 12 low also writes the mode payload.
// - Status reads are served in every operating mode.
// - Cause 0000 power-on or forced reset, 0001 cyclic wake, 0010 supply low.
// - Cause 0011 main supply overcurrent reset, 0100 third supply overload in sleep.
// - Cause 0101 flash exit done, 0110 ready to enter flash.
// - Cause 0111 CAN wake, 1000 LIN wake, 1001 local wake pin.
// - Cause 1010 fail-safe wake, 1011 watchdog overflow.
// - Cause 1100 watchdog init timeout, 1101 watchdog triggered too early.
// - Cause 1110 illegal serial access, 1111 interrupt service timeout.
// - Cause field overwritten on each reset event, never cleared.
// - Bit 7 latches CAN wake, cleared by status read.
// - Bit 6 latches LIN wake, cleared by status read.
// - Bit 5 latches falling wake pin edge, cleared by status read.
// - Bit 4 shows live wake pin level.
// - Bit 3 shows temperature warning.
// - Bit 2 shows software development mode.
// - Bit 1 shows enable pin driven high.
// - Bit 0 set by power-on, cleared once Normal mode entered.
// - Sleep with watchdog off: reset low at once, then supply off.
// - Frames need exactly sixteen clocks, else reported as error.
`timescale 1ns/100ps
`default_nettype none
module ssr_status_top #(
  parameter int FRAME_W = ssr_pkg::FRAME_BITS // Serial frame length
) (
  input wire logic clk_in, // 200 MHz system clock
  input wire logic reset_in, // Power-on reset, sync, active high
  input wire logic ce_in, // Clock enable, freezes all state
  input wire logic spi_sck_in, // Serial clock
  input wire logic spi_cs_n_in, // Chip select, active low
  input wire logic spi_mosi_in, // Host to device data
  output logic spi_miso_out, // Device to host data
  input wire logic [15:0] cause_event_in, // One pulse bit per reset cause code
  input wire logic can_wake_in, // CAN wake detected pulse
  input wire logic lin_wake_in, // LIN wake detected pulse
  input wire logic wake_pin_in, // Wake pin above threshold
  input wire logic overtemp_in, // Temperature warning level
  input wire logic sw_dev_mode_in, // Software development mode level
  input wire logic enable_pin_in, // Enable pin driven high
  input wire logic normal_entered_in, // Normal mode entered pulse
  input wire logic sleep_enter_in, // Sleep mode entry pulse
  input wire logic wd_off_sel_in, // Watchdog-off behaviour selected
  input wire logic sleep_exit_in, // Sleep left, restore supply and reset
  output logic mode_write_out, // Mode register write pulse
  output logic [11:0] mode_data_out, // Mode register payload
  output logic spi_error_out, // Clock-count failure pulse
  output logic [15:0] status_word_out, // Current status contents
  output logic reset_output_low_out, // Reset pin pulled low
  output logic watchdog_disable_out, // Watchdog held disabled
  output logic main_supply_on_out // Main supply regulator enable
);
  import ssr_pkg::*;

  // Shifter and header decode are built for sixteen-bit frames only
  if (FRAME_W != FRAME_BITS) begin : g_bad_frame_w
    $error("frame width must be sixteen");
  end

  ssr_if link ();

  ssr_spi_frame u_frame (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .ce_in(ce_in),
    .spi_sck_in(spi_sck_in),
    .spi_cs_n_in(spi_cs_n_in),
    .spi_mosi_in(spi_mosi_in),
    .spi_miso_out(spi_miso_out),
    .bus(link.frame)
  );

  // Highest pending cause wins when several coincide
  function automatic logic [3:0] ssr_encode_cause(input logic [15:0] ev);
    logic [3:0] code;
    code = CAUSE_POWERON;
    for (int i = 0; i < 16; i++) begin
      if (ev[i]) begin
        code = i[3:0];
      end
    end
    return code;
  endfunction

  function automatic logic ssr_is_status(input logic [3:0] h);
    return (h[HDR_SEL_HI:HDR_SEL_LO] == SEL_STATUS) && (h[HDR_BANK] == BANK_STATUS);
  endfunction

  logic [3:0] reset_cause;
  logic can_wake_flag;
  logic lin_wake_flag;
  logic edge_wake_flag;
  logic wake_pin_level;
  logic wake_prev;
  logic overtemp_warning;
  logic sw_dev_mode_flag;
  logic enable_pin_state;
  logic poweron_flag;
  logic [2:0] shown_wake;
  logic shown_valid;
  logic shown_write;
  logic status_read;
  logic edge_wake_evt;
  logic [11:0] status_low;
  ssr_sleep_t sleep_state;
  ssr_sleep_t next_sleep_state;

  assign edge_wake_evt = wake_prev & ~wake_pin_in;

  // Live bits, refreshed every cycle
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      wake_pin_level <= 1'b0;
      wake_prev <= 1'b0;
      overtemp_warning <= 1'b0;
      sw_dev_mode_flag <= 1'b0;
      enable_pin_state <= 1'b0;
    end else if (ce_in) begin
      wake_pin_level <= wake_pin_in;
      wake_prev <= wake_pin_in;
      overtemp_warning <= overtemp_in;
      sw_dev_mode_flag <= sw_dev_mode_in;
      enable_pin_state <= enable_pin_in;
    end
  end

  // Cause field: updated on any event, never cleared
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      reset_cause <= RESET_CAUSE;
    end else if (ce_in && (cause_event_in != 16'h0000)) begin
      reset_cause <= ssr_encode_cause(cause_event_in);
    end
  end

  // Power-on flag
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      poweron_flag <= RESET_POWERON_FLAG;
    end else if (ce_in) begin
      if (cause_event_in[CAUSE_POWERON]) begin
        poweron_flag <= 1'b1;
      end else if (normal_entered_in) begin
        poweron_flag <= 1'b0;
      end
    end
  end

  // Read word loaded into the shifter once the header is known
  assign status_low = {reset_cause, can_wake_flag, lin_wake_flag, edge_wake_flag,
    wake_pin_level, overtemp_warning, sw_dev_mode_flag, enable_pin_state, poweron_flag};
  assign link.load_word = ssr_is_status(link.hdr) ? status_low : 12'h000;

  // Remember which flags the host actually saw
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      shown_wake <= 3'h0;
      shown_valid <= 1'b0;
      shown_write <= 1'b0;
    end else if (ce_in) begin
      if (link.hdr_valid) begin
        shown_wake <= {can_wake_flag, lin_wake_flag, edge_wake_flag};
        shown_valid <= ssr_is_status(link.hdr);
        shown_write <= ~link.hdr[HDR_NOWRITE];
      end else if (link.frame_done) begin
        shown_valid <= 1'b0;
      end
    end
  end

  // Only a complete, valid status frame clears the flags
  assign status_read = link.frame_done & link.frame_ok & shown_valid;

  // Wake flags: set wins over clear, only reported bits clear
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      can_wake_flag <= 1'b0;
      lin_wake_flag <= 1'b0;
      edge_wake_flag <= 1'b0;
    end else if (ce_in) begin
      can_wake_flag <= (can_wake_flag & ~(status_read & shown_wake[2])) | can_wake_in;
      lin_wake_flag <= (lin_wake_flag & ~(status_read & shown_wake[1])) | lin_wake_in;
      edge_wake_flag <= (edge_wake_flag & ~(status_read & shown_wake[0]))
        | edge_wake_evt;
    end
  end

  // Mode register payload on read-and-write frames
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      mode_write_out <= 1'b0;
      mode_data_out <= RESET_MODE_DATA;
    end else if (ce_in) begin
      mode_write_out <= status_read & shown_write;
      if (status_read && shown_write) begin
        mode_data_out <= link.rx_word[11:0];
      end
    end
  end

  // Clock-count failure report
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      spi_error_out <= 1'b0;
    end else if (ce_in) begin
      spi_error_out <= link.frame_done & ~link.frame_ok;
    end
  end

  // Status mirror
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      status_word_out <= 16'h0000;
    end else if (ce_in) begin
      status_word_out <= {4'h0, status_low};
    end
  end

  // Sleep entry: reset low first, supply off on the next cycle
  always_comb begin
    next_sleep_state = sleep_state;
    unique case (sleep_state)
      SSR_RUN: begin
        if (sleep_enter_in && wd_off_sel_in) begin
          next_sleep_state = SSR_RST_LOW;
        end
      end
      SSR_RST_LOW: begin
        next_sleep_state = SSR_SUPPLY_OFF;
      end
      SSR_SUPPLY_OFF: begin
        if (sleep_exit_in) begin
          next_sleep_state = SSR_RUN;
        end
      end
      default: begin
        next_sleep_state = SSR_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      sleep_state <= SSR_RUN;
    end else if (ce_in) begin
      sleep_state <= next_sleep_state;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      reset_output_low_out <= 1'b0;
      watchdog_disable_out <= 1'b0;
      main_supply_on_out <= 1'b1;
    end else if (ce_in) begin
      reset_output_low_out <= (next_sleep_state != SSR_RUN);
      watchdog_disable_out <= (next_sleep_state != SSR_RUN);
      main_supply_on_out <= (next_sleep_state != SSR_SUPPLY_OFF);
    end
  end
endmodule // ssr_status_top
`default_nettype wire

// >>> common/ssr_pkg.sv
// Constants for the system status readback block
package ssr_pkg;
  localparam int FRAME_BITS = 16;
  localparam int HDR_BITS = 4;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] CNT_MAX = 5'h1F;
  localparam logic [CNT_W-1:0] CNT_HDR = 5'h04;
  localparam logic [CNT_W-1:0] CNT_FRAME = 5'h10;
  // Header layout, bits 15..12 of the host frame
  localparam int HDR_SEL_HI = 3;
  localparam int HDR_SEL_LO = 2;
  localparam int HDR_BANK = 1;
  localparam int HDR_NOWRITE = 0;
  localparam logic [1:0] SEL_STATUS = 2'h0;
  localparam logic BANK_STATUS = 1'b0;
  // Status word field positions
  localparam int POS_CAUSE_HI = 11;
  localparam int POS_CAUSE_LO = 8;
  localparam int POS_CAN_WAKE = 7;
  localparam int POS_LIN_WAKE = 6;
  localparam int POS_EDGE_WAKE = 5;
  localparam int POS_WAKE_LEVEL = 4;
  localparam int POS_OVERTEMP = 3;
  localparam int POS_SW_DEV = 2;
  localparam int POS_ENABLE_PIN = 1;
  localparam int POS_POWERON = 0;
  // Reset cause codes
  localparam logic [3:0] CAUSE_POWERON = 4'h0;
  localparam logic [3:0] CAUSE_CYCLIC_WAKE = 4'h1;
  localparam logic [3:0] CAUSE_MAIN_LOW = 4'h2;
  localparam logic [3:0] CAUSE_MAIN_OVERCURRENT = 4'h3;
  localparam logic [3:0] CAUSE_THIRD_OVERLOAD = 4'h4;
  localparam logic [3:0] CAUSE_FLASH_EXIT = 4'h5;
  localparam logic [3:0] CAUSE_FLASH_READY = 4'h6;
  localparam logic [3:0] CAUSE_CAN_WAKE = 4'h7;
  localparam logic [3:0] CAUSE_LIN_WAKE = 4'h8;
  localparam logic [3:0] CAUSE_LOCAL_WAKE = 4'h9;
  localparam logic [3:0] CAUSE_FAILSAFE_WAKE = 4'hA;
  localparam logic [3:0] CAUSE_WD_OVERFLOW = 4'hB;
  localparam logic [3:0] CAUSE_WD_INIT = 4'hC;
  localparam logic [3:0] CAUSE_WD_EARLY = 4'hD;
  localparam logic [3:0] CAUSE_ILLEGAL_SPI = 4'hE;
  localparam logic [3:0] CAUSE_IRQ_TIMEOUT = 4'hF;
  localparam logic [3:0] RESET_CAUSE = CAUSE_POWERON;
  localparam logic RESET_POWERON_FLAG = 1'b1;
  localparam logic [11:0] RESET_MODE_DATA = 12'h000;
  typedef enum logic [1:0] {
    SSR_RUN = 2'h0,
    SSR_RST_LOW = 2'h1,
    SSR_SUPPLY_OFF = 2'h3
  } ssr_sleep_t;
endpackage

// >>> common/ssr_if.sv
// Carrier between the serial frame engine and the status core
`timescale 1ns/100ps
`default_nettype none
interface ssr_if;
  logic hdr_valid;
  logic [3:0] hdr;
  logic [11:0] load_word;
  logic frame_done;
  logic frame_ok;
  logic [15:0] rx_word;
  modport frame (output hdr_valid, output hdr, input load_word,
    output frame_done, output frame_ok, output rx_word);
  modport core (input hdr_valid, input hdr, output load_word,
    input frame_done, input frame_ok, input rx_word);
endinterface
`default_nettype wire

// >>> hw/ssr_spi_frame.sv
// Serial frame engine: shifts a 16-bit full-duplex frame
`timescale 1ns/100ps
`default_nettype none
module ssr_spi_frame (
  input wire logic clk_in, // System clock
  input wire logic reset_in, // Synchronous reset, active high
  input wire logic ce_in, // Clock enable
  input wire logic spi_sck_in, // Serial clock, sampled
  input wire logic spi_cs_n_in, // Chip select, active low
  input wire logic spi_mosi_in, // Host data in
  output logic spi_miso_out, // Device data out
  ssr_if.frame bus // Link to status core
);
  import ssr_pkg::*;
  logic sck_prev;
  logic cs_prev_n;
  logic [CNT_W-1:0] bit_cnt;
  logic [15:0] rx;
  logic [15:0] tx;
  logic done;
  logic ok;
  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic cs_rise;

  assign sck_rise = spi_sck_in & ~sck_prev & ~spi_cs_n_in;
  assign sck_fall = ~spi_sck_in & sck_prev & ~spi_cs_n_in;
  assign cs_fall = ~spi_cs_n_in & cs_prev_n;
  assign cs_rise = spi_cs_n_in & ~cs_prev_n;
  // Header known on the fourth rising edge
  assign bus.hdr_valid = sck_rise & (bit_cnt == CNT_HDR - 5'h01);
  assign bus.hdr = {rx[2:0], spi_mosi_in};
  assign bus.frame_done = done;
  assign bus.frame_ok = ok;
  assign bus.rx_word = rx;
  assign spi_miso_out = tx[15];

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      sck_prev <= 1'b0;
      cs_prev_n <= 1'b1;
    end else if (ce_in) begin
      sck_prev <= spi_sck_in;
      cs_prev_n <= spi_cs_n_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      bit_cnt <= '0;
      rx <= '0;
    end else if (ce_in) begin
      if (cs_fall) begin
        bit_cnt <= '0;
      end else if (sck_rise) begin
        rx <= {rx[14:0], spi_mosi_in};
        if (bit_cnt != CNT_MAX) begin
          bit_cnt <= bit_cnt + 5'h01;
        end
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      tx <= '0;
    end else if (ce_in) begin
      if (cs_fall) begin
        tx <= '0;
      end else if (bus.hdr_valid) begin
        tx <= {1'b0, bus.load_word, 3'h0};
      end else if (sck_fall) begin
        tx <= {tx[14:0], 1'b0};
      end
    end
  end

  // Frame end and clock-count check
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      done <= 1'b0;
      ok <= 1'b0;
    end else if (ce_in) begin
      done <= cs_rise;
      ok <= cs_rise & (bit_cnt == CNT_FRAME);
    end
  end
endmodule // ssr_spi_frame
`default_nettype wire

// >>> testbench/ssr_properties.sv
// Concurrent checks on the status readback ports
`timescale 1ns/100ps
`default_nettype none
module ssr_properties (
  input wire logic clk_in, // Clock
  input wire logic reset_in, // Reset
  input wire logic ce_in, // Enable
  input wire logic [15:0] cause_event_in, // Cause pulses
  input wire logic can_wake_in, // CAN wake
  input wire logic lin_wake_in, // LIN wake
  input wire logic wake_pin_in, // Wake pin
  input wire logic overtemp_in, // Temp warning
  input wire logic sw_dev_mode_in, // Dev mode
  input wire logic enable_pin_in, // Enable pin
  input wire logic normal_entered_in, // Normal entered
  input wire logic sleep_enter_in, // Sleep entry
  input wire logic wd_off_sel_in, // Watchdog off
  input wire logic mode_write_out, // Mode write
  input wire logic spi_error_out, // Count error
  input wire logic [15:0] status_word_out, // Status
  input wire logic reset_output_low_out, // Reset low
  input wire logic watchdog_disable_out, // Watchdog off
  input wire logic main_supply_on_out // Supply on
);
  logic [3:0] hi_code;
  always_comb begin
    hi_code = 4'h0;
    for (int i = 0; i < 16; i++) if (cause_event_in[i]) hi_code = i[3:0];
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in || !ce_in);
  cause_capture_a:
    assert property (cause_event_in != 16'h0000 |->
      ##2 status_word_out[11:8] == $past(hi_code, 2))
    else $error("reset cause not captured");
  cause_hold_a:
    assert property (cause_event_in == 16'h0000 ##1 cause_event_in == 16'h0000 |=>
      $stable(status_word_out[11:8]))
    else $error("reset cause changed without event");
  can_flag_a:
    assert property (can_wake_in |-> ##2 status_word_out[7]) else $error("CAN flag not set");
  lin_flag_a:
    assert property (lin_wake_in |-> ##2 status_word_out[6]) else $error("LIN flag not set");
  edge_flag_a:
    assert property ($fell(wake_pin_in) && !$past(reset_in) |-> ##2 status_word_out[5])
    else $error("edge flag not set");
  live_bits_a:
    assert property (!$past(reset_in) && !$past(reset_in, 2) |-> status_word_out[4:1] ==
      $past({wake_pin_in, overtemp_in, sw_dev_mode_in, enable_pin_in}, 2))
    else $error("live bits wrong");
  poweron_clear_a:
    assert property (normal_entered_in && !cause_event_in[0] |-> ##2 !status_word_out[0])
    else $error("power flag kept");
  sleep_reset_a:
    assert property (sleep_enter_in && wd_off_sel_in && main_supply_on_out &&
      !reset_output_low_out |=> reset_output_low_out && watchdog_disable_out)
    else $error("reset not pulled at sleep");
  supply_late_a:
    assert property ($rose(reset_output_low_out) |-> main_supply_on_out ##1 !main_supply_on_out)
    else $error("supply order wrong");
  pulse_apart_a:
    assert property (mode_write_out |-> !spi_error_out ##1 !mode_write_out)
    else $error("write pulse wrong");
endmodule // ssr_properties
`default_nettype wire

// >>> testbench/ssr_host_model.sv
// Host model: serial master sending one frame per request
`timescale 1ns/100ps
`default_nettype none
module ssr_host_model (
  input wire logic clk_in, // Clock
  input wire logic go_in, // Start frame
  input wire logic [15:0] word_in, // Word, MSB first
  input wire logic [4:0] count_in, // Serial clocks
  input wire logic miso_in, // Device data
  output logic sck_out, // Serial clock, idle low
  output logic cs_n_out, // Select, active low
  output logic mosi_out, // Host data
  output logic [15:0] rx_out, // Captured word
  output logic done_out // Frame done pulse
);
  logic [15:0] sh;
  initial begin
    sck_out = 1'b0;
    cs_n_out = 1'b1;
    mosi_out = 1'b0;
    done_out = 1'b0;
    rx_out = 16'h0000;
    forever begin
      @(posedge clk_in);
      if (go_in) begin
        sh = word_in;
        cs_n_out <= 1'b0;
        mosi_out <= sh[15];
        repeat (3) @(posedge clk_in);
        for (int i = 0; i < count_in; i++) begin
          sck_out <= 1'b1;
          rx_out <= {rx_out[14:0], miso_in};
          sh = sh << 1;
          repeat (3) @(posedge clk_in);
          sck_out <= 1'b0;
          mosi_out <= sh[15];
          repeat (3) @(posedge clk_in);
        end
        cs_n_out <= 1'b1;
        mosi_out <= ~mosi_out;
        done_out <= 1'b1;
        @(posedge clk_in);
        done_out <= 1'b0;
      end
    end
  end
endmodule // ssr_host_model
`default_nettype wire

// >>> testbench/system_status_readback_tb.sv
// Testbench for the system status readback register
`timescale 1ns/100ps
`default_nettype none
module system_status_readback_tb;
  logic clk_in, reset_in, ce_in, spi_sck_in, spi_cs_n_in, spi_mosi_in, spi_miso_out, go, done;
  logic can_wake_in, lin_wake_in, wake_pin_in, overtemp_in, sw_dev_mode_in, enable_pin_in;
  logic normal_entered_in, sleep_enter_in, wd_off_sel_in, sleep_exit_in, mode_write_out;
  logic spi_error_out, reset_output_low_out, watchdog_disable_out, main_supply_on_out;
  logic [15:0] cause_event_in, status_word_out, word, rx;
  logic [11:0] mode_data_out;
  logic [4:0] count;
  logic clash = 1'b0;
  int num_errors = 0, num_checks = 0, wr_cnt = 0, err_cnt = 0, cycles = 0;
  ssr_status_top u_dut (.clk_in, .reset_in, .ce_in, .spi_sck_in, .spi_cs_n_in, .spi_mosi_in,
    .spi_miso_out, .cause_event_in, .can_wake_in, .lin_wake_in, .wake_pin_in, .overtemp_in,
    .sw_dev_mode_in, .enable_pin_in, .normal_entered_in, .sleep_enter_in, .wd_off_sel_in,
    .sleep_exit_in, .mode_write_out, .mode_data_out, .spi_error_out, .status_word_out,
    .reset_output_low_out, .watchdog_disable_out, .main_supply_on_out);
  ssr_host_model u_host (.clk_in, .go_in(go), .word_in(word), .count_in(count),
    .miso_in(spi_miso_out), .sck_out(spi_sck_in), .cs_n_out(spi_cs_n_in),
    .mosi_out(spi_mosi_in), .rx_out(rx), .done_out(done));
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk_in) begin
    cycles++;
    if (mode_write_out) wr_cnt++;
    if (spi_error_out) err_cnt++;
    if (cycles == 20000) begin
      num_errors++;
      wrap_up();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic frame(input logic [15:0] w, input logic [4:0] n);
    word <= w;
    count <= n;
    go <= 1'b1;
    tick(1);
    go <= 1'b0;
    for (int i = 0; i < 400 && done !== 1'b1; i++) tick(1);
    check({15'h0, done}, 16'h0001);
    // Optional CAN wake on the flag-clearing edge
    can_wake_in <= clash;
    tick(1);
    can_wake_in <= 1'b0;
    tick(3);
  endtask
  // Foreign header: zeros back, no clear, no write
  task automatic refused(input logic [15:0] w);
    frame(w, 5'h10);
    check(rx, 16'h0000);
    check(status_word_out, 16'h0FEF);
    check(wr_cnt[15:0], 16'h0000);
  endtask
  initial begin
    {reset_in, ce_in} = 2'b11;
    {go, can_wake_in, lin_wake_in, wake_pin_in, overtemp_in, sw_dev_mode_in} = 6'h00;
    {enable_pin_in, normal_entered_in, sleep_enter_in, wd_off_sel_in, sleep_exit_in} = 5'h00;
    cause_event_in = 16'h0000;
    word = 16'h0000;
    count = 5'h10;
    tick(8);
    reset_in <= 1'b0;
    tick(2);
    check(status_word_out, 16'h0001);
    for (int i = 0; i < 16; i++) begin
      cause_event_in <= 16'h0001 << i;
      tick(1);
      cause_event_in <= 16'h0000;
      tick(2);
      check(status_word_out, {4'h0, i[3:0], 8'h01});
    end
    {wake_pin_in, overtemp_in, sw_dev_mode_in, enable_pin_in} <= 4'hF;
    tick(3);
    check(status_word_out, 16'h0F1F);
    {wake_pin_in, can_wake_in, lin_wake_in} <= 3'b011;
    tick(1);
    {can_wake_in, lin_wake_in} <= 2'b00;
    tick(2);
    check(status_word_out, 16'h0FEF);
    refused(16'h2000);
    refused(16'hC000);
    frame(16'h1000, 5'h0F);
    frame(16'h1000, 5'h11);
    check(err_cnt[15:0], 16'h0002);
    check(status_word_out, 16'h0FEF);
    frame(16'h1000, 5'h10);
    check(rx, 16'h0FEF);
    check(status_word_out, 16'h0F0F);
    check(wr_cnt[15:0], 16'h0000);
    frame(16'h0ABC, 5'h10);
    check(wr_cnt[15:0], 16'h0001);
    check({4'h0, mode_data_out}, 16'h0ABC);
    normal_entered_in <= 1'b1;
    tick(1);
    normal_entered_in <= 1'b0;
    tick(2);
    check(status_word_out, 16'h0F0E);
    sleep_enter_in <= 1'b1;
    tick(1);
    sleep_enter_in <= 1'b0;
    tick(2);
    check({13'h0, reset_output_low_out, watchdog_disable_out, main_supply_on_out}, 16'h1);
    {wd_off_sel_in, sleep_enter_in} <= 2'b11;
    tick(1);
    sleep_enter_in <= 1'b0;
    #1 check({13'h0, reset_output_low_out, watchdog_disable_out, main_supply_on_out}, 16'h7);
    tick(1);
    #1 check({13'h0, reset_output_low_out, watchdog_disable_out, main_supply_on_out}, 16'h6);
    tick(1);
    can_wake_in <= 1'b1;
    tick(1);
    can_wake_in <= 1'b0;
    clash = 1'b1;
    frame(16'h1000, 5'h10);
    clash = 1'b0;
    check(rx, 16'h0F8E);
    check(status_word_out, 16'h0F8E);
    sleep_exit_in <= 1'b1;
    tick(1);
    sleep_exit_in <= 1'b0;
    tick(2);
    check({13'h0, reset_output_low_out, watchdog_disable_out, main_supply_on_out}, 16'h1);
    reset_in <= 1'b1;
    tick(2);
    reset_in <= 1'b0;
    tick(2);
    check(status_word_out, 16'h0001);
    tick(1);
    check(status_word_out, 16'h000F);
    wrap_up();
  end
endmodule // system_status_readback_tb
bind ssr_status_top ssr_properties u_props (.clk_in, .reset_in, .ce_in, .cause_event_in,
  .can_wake_in, .lin_wake_in, .wake_pin_in, .overtemp_in, .sw_dev_mode_in, .enable_pin_in,
  .normal_entered_in, .sleep_enter_in, .wd_off_sel_in, .mode_write_out, .spi_error_out,
  .status_word_out, .reset_output_low_out, .watchdog_disable_out, .main_supply_on_out);
`default_nettype wire
